// >>> logic/otw_watchdog.sv
// one-time enabled watchdog with reset-out pulse
module otw_watchdog
  import otw_pkg::*;
#(
  parameter int CNT_WIDTH = OTW_CNT_WIDTH,
  parameter int OSC_PER_CLK = 1,
  parameter int PULSE_OSC = OTW_PULSE_OSC_PERIODS
) (
  input wire logic CORE_CLK_IN,        // oscillator clock, 100 MHz
  input wire logic RST_N_IN,           // synchronous reset, active low
  input wire logic SFR_WR_IN,          // special-function write strobe
  input wire logic [7:0] SFR_ADDR_IN,  // special-function address
  input wire logic [7:0] SFR_WDATA_IN, // special-function write data
  input wire logic IDLE_IN,            // processor in idle mode
  input wire logic POWER_DOWN_IN,      // processor in power-down
  input wire logic WAKE_INT_N_IN,      // level wake interrupt pin, low active
  input wire logic IDLE_HALT_SEL_IN,   // idle-halt option from aux control reg
  output logic ARMED_OUT,              // watchdog armed
  output logic RST_PIN_OUT,            // reset pin drive level, high = reset
  output logic RST_PIN_OE_OUT,         // reset pin output enable
  output logic DEV_RESET_OUT           // overflow reset request to the device
);
  // prescaler and pulse lengths in core clocks
  localparam int MACH_CLKS = OTW_OSC_PER_MACHINE / OSC_PER_CLK;
  localparam int PULSE_CLKS = (PULSE_OSC + OSC_PER_CLK - 1) / OSC_PER_CLK;
  localparam logic [3:0] MACH_LAST = 4'(MACH_CLKS - 1);
  localparam logic [7:0] PULSE_LAST = 8'(PULSE_CLKS - 1);
  localparam logic [CNT_WIDTH-1:0] CNT_TOP = CNT_WIDTH'(OTW_CNT_LIMIT);

  // refuse shapes that the narrow counters cannot hold
  initial begin
    if (CNT_WIDTH != OTW_CNT_WIDTH) begin
      $error("otw_watchdog: counter width must stay at fourteen bits");
    end
    if (OSC_PER_CLK < 1 || OTW_OSC_PER_MACHINE % OSC_PER_CLK != 0) begin
      $error("otw_watchdog: clocks per period must divide a machine cycle");
    end
    if (MACH_CLKS < 1 || MACH_CLKS > 16) begin
      $error("otw_watchdog: machine-cycle prescaler does not fit four bits");
    end
    if (PULSE_CLKS < 1 || PULSE_CLKS > 256) begin
      $error("otw_watchdog: reset pulse length does not fit eight bits");
    end
  end

  // all state in one word: arming, key progress, count, prescaler,
  // wake hold-off and the reset-out pulse
  typedef struct packed {
    logic armed;
    otw_key_t key;
    logic [CNT_WIDTH-1:0] cnt;
    logic [3:0] mach;
    logic wake_hold;
    logic pulse;
    logic [7:0] pulse_cnt;
    logic dev_rst;
  } otw_state_t;

  otw_state_t st_r;
  otw_state_t st_nxt;
  logic wake_n_sync;
  logic svc_wr;
  logic key_done;
  logic run;
  logic idle_freeze;
  logic pd_hold;

  // a write reaches the service register only at its own address
  function automatic logic svc_hit(input logic wr, input logic [7:0] addr);
    return wr && (addr == OTW_SERVICE_ADDR);
  endfunction : svc_hit

  // next step of the key sequence; a wrong byte drops back to the start
  function automatic otw_key_t key_step(input otw_key_t cur, input logic [7:0] data);
    otw_key_t nxt;
    nxt = OTW_KEY_IDLE;
    unique case (cur)
      OTW_KEY_IDLE: begin
        nxt = (data == OTW_KEY_FIRST) ? OTW_KEY_HALF : OTW_KEY_IDLE;
      end
      OTW_KEY_HALF: begin
        // a failing second byte is not taken as a new first byte
        nxt = OTW_KEY_IDLE;
      end
      default: begin
        nxt = OTW_KEY_IDLE;
      end
    endcase
    return nxt;
  endfunction : key_step

  // the pair is complete when the second byte follows the first
  function automatic logic key_complete(input otw_key_t cur, input logic [7:0] data);
    return (cur == OTW_KEY_HALF) && (data == OTW_KEY_SECOND);
  endfunction : key_complete

  // last prescaler clock of a machine cycle
  function automatic logic mach_end(input logic [3:0] mach);
    return mach == MACH_LAST;
  endfunction : mach_end

  // counter has reached its top value
  function automatic logic cnt_at_top(input logic [CNT_WIDTH-1:0] cnt);
    return cnt == CNT_TOP;
  endfunction : cnt_at_top

  // last clock of the reset-out pulse
  function automatic logic pulse_done(input logic [7:0] pcnt);
    return pcnt == PULSE_LAST;
  endfunction : pulse_done

  // the wake pin is asynchronous: two flops before any logic sees it
  otw_sync #(
    .RESET_VAL(1'b1)
  ) u_wake_sync (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in(WAKE_INT_N_IN),
    .q_out(wake_n_sync)
  );

  always_comb begin
    st_nxt = st_r;
    svc_wr = svc_hit(SFR_WR_IN, SFR_ADDR_IN);
    key_done = svc_wr && key_complete(st_r.key, SFR_WDATA_IN);
    // key sequence: two consecutive writes to the service register
    if (svc_wr) begin
      st_nxt.key = key_step(st_r.key, SFR_WDATA_IN);
    end
    // arming is one-way; only overflow or reset clears it
    if (key_done) begin
      st_nxt.armed = 1'b1;
    end
    // after waking by interrupt the count stays off until the pin is high
    if (POWER_DOWN_IN) begin
      st_nxt.wake_hold = 1'b1;
    end else if (wake_n_sync) begin
      st_nxt.wake_hold = 1'b0;
    end
    // the oscillator is stopped in power-down, so the count simply holds
    pd_hold = POWER_DOWN_IN || st_r.wake_hold;
    // idle only freezes the count when the idle-halt option is set
    idle_freeze = IDLE_IN && IDLE_HALT_SEL_IN;
    run = st_r.armed && !pd_hold && !idle_freeze;
    st_nxt.dev_rst = 1'b0;
    // a service pair restarts both the count and the prescaler
    if (key_done && st_r.armed) begin
      st_nxt.cnt = OTW_CNT_ZERO;
      st_nxt.mach = 4'h0;
    end else if (run) begin
      if (mach_end(st_r.mach)) begin
        st_nxt.mach = 4'h0;
        // overflow disarms at once so the pulse cannot retrigger itself
        if (cnt_at_top(st_r.cnt)) begin
          st_nxt.pulse = 1'b1;
          st_nxt.pulse_cnt = 8'h00;
          st_nxt.dev_rst = 1'b1;
          st_nxt.armed = 1'b0;
          st_nxt.cnt = OTW_CNT_ZERO;
          st_nxt.key = OTW_KEY_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end else begin
        st_nxt.mach = st_r.mach + 4'h1;
      end
    end
    // reset-out pulse on the pin, whole oscillator periods
    if (st_r.pulse) begin
      st_nxt.dev_rst = 1'b1;
      // the device reset request stays up for the whole pulse
      if (pulse_done(st_r.pulse_cnt)) begin
        st_nxt.pulse = 1'b0;
        st_nxt.dev_rst = 1'b0;
      end else begin
        st_nxt.pulse_cnt = st_r.pulse_cnt + 8'h01;
      end
    end
  end

  // one register for the whole state word
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      st_r <= '{
        armed: 1'b0,
        key: OTW_KEY_IDLE,
        cnt: OTW_CNT_ZERO,
        mach: 4'h0,
        wake_hold: 1'b0,
        pulse: 1'b0,
        pulse_cnt: 8'h00,
        dev_rst: 1'b0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output is a bit of the state register
  assign ARMED_OUT = st_r.armed;
  assign RST_PIN_OUT = st_r.pulse;
  assign RST_PIN_OE_OUT = st_r.pulse;
  assign DEV_RESET_OUT = st_r.dev_rst;
endmodule : otw_watchdog

// >>> logic/otw_pkg.sv
// package: constants and types of the one-time enabled watchdog
package otw_pkg;
  localparam logic [7:0] OTW_SERVICE_ADDR = 8'ha6;
  localparam logic [7:0] OTW_KEY_FIRST = 8'h1e;
  localparam logic [7:0] OTW_KEY_SECOND = 8'he1;
  localparam int OTW_CNT_WIDTH = 14;
  localparam logic [13:0] OTW_CNT_LIMIT = 14'h3fff;
  localparam logic [13:0] OTW_CNT_ZERO = 14'h0000;
  localparam int OTW_OSC_PER_MACHINE = 12;
  localparam int OTW_PULSE_OSC_PERIODS = 98;
  localparam int OTW_CLK_PERIOD_NS = 10;
  typedef enum logic [1:0] {
    OTW_KEY_IDLE = 2'b00,
    OTW_KEY_HALF = 2'b01
  } otw_key_t;
endpackage : otw_pkg

// >>> logic/otw_sync.sv
// two-flop synchroniser for a pin level
module otw_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_in,    // core clock
  input wire logic rst_n_in,  // synchronous reset, active low
  input wire logic d_in,      // asynchronous level
  output logic q_out          // synchronised level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } otw_sync_state_t;
  otw_sync_state_t st_r;
  otw_sync_state_t st_nxt;
  always_comb begin
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= '{s1: RESET_VAL, s2: RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q_out = st_r.s2;
endmodule : otw_sync

// >>> verif/otw_props.sv
// checker of the watchdog port behaviour
module otw_props
  import otw_pkg::*;
(
  input wire logic CORE_CLK_IN,       // clock
  input wire logic RST_N_IN,          // reset
  input wire logic SFR_WR_IN,         // strobe
  input wire logic [7:0] SFR_ADDR_IN, // address
  input wire logic [7:0] SFR_WDATA_IN, // data
  input wire logic POWER_DOWN_IN,     // power-down
  input wire logic ARMED_OUT,         // armed
  input wire logic RST_PIN_OUT,       // pin level
  input wire logic RST_PIN_OE_OUT,    // pin enable
  input wire logic DEV_RESET_OUT      // reset request
);
  wire logic kw = SFR_WR_IN && SFR_ADDR_IN == OTW_SERVICE_ADDR;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  chk_reset_clears: assert property ($rose(RST_N_IN) |-> !ARMED_OUT && !RST_PIN_OUT && !DEV_RESET_OUT)
    else $error("outputs not clear after reset");
  chk_oe_follows: assert property (RST_PIN_OE_OUT == RST_PIN_OUT)
    else $error("pin enable differs from level");
  chk_key_arms: assert property (kw && SFR_WDATA_IN == OTW_KEY_FIRST ##2 kw && SFR_WDATA_IN == OTW_KEY_SECOND |=> ARMED_OUT)
    else $error("key pair did not arm");
  chk_arm_cause: assert property ($rose(ARMED_OUT) |-> $past(kw) && $past(SFR_WDATA_IN) == OTW_KEY_SECOND)
    else $error("armed without second key");
  chk_no_disarm: assert property (ARMED_OUT |=> ARMED_OUT || DEV_RESET_OUT)
    else $error("disarmed without reset");
  chk_pulse_len: assert property ($rose(RST_PIN_OUT) |-> (RST_PIN_OUT throughout ##97 1'b1) ##1 !RST_PIN_OUT)
    else $error("reset pulse length wrong");
  chk_ovf_reset: assert property ($rose(RST_PIN_OUT) |-> DEV_RESET_OUT && !ARMED_OUT && $past(ARMED_OUT))
    else $error("overflow reset wrong");
  chk_pd_frozen: assert property (POWER_DOWN_IN && !RST_PIN_OUT |=> !RST_PIN_OUT)
    else $error("overflow in power-down");
endmodule : otw_props
bind otw_watchdog otw_props u_props (.*);

// >>> verif/otw_watchdog_tb_top.sv
// testbench of the watchdog
module otw_watchdog_tb_top
  import otw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, wr = 0, idle = 0, pd = 0, wake_n = 1, sel = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  logic armed, pin, oe, dev;
  int miscompares = 0, tests_run = 0, n, m;
  // twelve oscillator periods per clock give one clock per machine cycle
  otw_watchdog #(.OSC_PER_CLK(12), .PULSE_OSC(1176)) u_dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
    .SFR_WR_IN(wr), .SFR_ADDR_IN(addr), .SFR_WDATA_IN(wd), .IDLE_IN(idle), .POWER_DOWN_IN(pd),
    .WAKE_INT_N_IN(wake_n), .IDLE_HALT_SEL_IN(sel), .ARMED_OUT(armed), .RST_PIN_OUT(pin),
    .RST_PIN_OE_OUT(oe), .DEV_RESET_OUT(dev));
  initial forever #5 clk = ~clk;
  task report_and_stop();
    $display("mismatches %0d of %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task cmp(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  task put(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, addr, wd} = {1'b1, a, d};
    @(negedge clk);
    wr = 0;
  endtask : put
  task key();
    put(OTW_SERVICE_ADDR, OTW_KEY_FIRST);
    put(OTW_SERVICE_ADDR, OTW_KEY_SECOND);
  endtask : key
  // waits up to c cycles for the reset pulse, n holds the cycles waited
  task run(input int c);
    n = 0;
    while (n < c && pin !== 1'b1) begin
      @(negedge clk);
      n++;
    end
  endtask : run
  task rst();
    rst_n = 0;
    repeat (10) @(negedge clk);
    rst_n = 1;
  endtask : rst
  initial begin
    rst();
    cmp(armed, 0);
    put(8'ha5, OTW_KEY_FIRST);
    put(8'ha5, OTW_KEY_SECOND);
    put(OTW_SERVICE_ADDR, OTW_KEY_FIRST);
    put(OTW_SERVICE_ADDR, 8'h55);
    put(OTW_SERVICE_ADDR, OTW_KEY_SECOND);
    @(negedge clk);
    cmp(armed, 0);
    key();
    put(OTW_SERVICE_ADDR, 8'h00);
    cmp(armed, 1);
    idle = 1;
    run(5000);
    cmp(n, 5000);
    key();
    run(17000);
    cmp(n, 16384);
    cmp(oe, 1);
    cmp(dev, 1);
    m = 0;
    while (pin === 1'b1 && m < 200) begin
      @(negedge clk);
      m++;
    end
    cmp(m, 98);
    cmp(armed, 0);
    rst();
    cmp(armed, 0);
    idle = 0;
    sel = 1;
    key();
    run(8000);
    idle = 1;
    run(9000);
    cmp(n, 9000);
    idle = 0;
    pd = 1;
    wake_n = 0;
    run(2000);
    pd = 0;
    run(9000);
    cmp(n, 9000);
    wake_n = 1;
    run(9000);
    cmp(n >= 8376 && n <= 8400, 1);
    rst();
    key();
    run(3000);
    key();
    pd = 1;
    wake_n = 0;
    run(500);
    pd = 0;
    wake_n = 1;
    key();
    run(17000);
    cmp(n, 16384);
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule : otw_watchdog_tb_top
